// >>> core/ldp_pkg.sv
// shared constants of the led driver protection and supervision block
package ldp_pkg;
  // serial interface
  localparam int SHIFT_WIDTH = 40;
  localparam int ADDR_WIDTH = 4;
  localparam logic [3:0] ADDR_RESTART = 4'h9;
  localparam logic [3:0] ADDR_STATUS = 4'ha;
  // status snapshot word layout
  localparam int SNAP_WIDTH = 36;
  localparam int SNAP_OPEN_BIT = 0;
  localparam int SNAP_SHORT_BIT = 1;
  localparam int SNAP_OVER_BIT = 2;
  localparam int SNAP_PRETHERM_BIT = 3;
  localparam int SNAP_THERM_BIT = 4;
  localparam int SNAP_FLAG_COUNT = 5;
  // grayscale timing, counted in grayscale clocks
  localparam int GS_WIDTH = 12;
  localparam int GS_COUNT_WIDTH = 13;
  localparam logic [12:0] GS_BOOST_FIRST = 13'h0010;
  localparam logic [12:0] GS_LED_FIRST = 13'h0011;
  localparam logic [12:0] GS_SAMPLE = 13'h0021;
  localparam logic [12:0] GS_PERIOD = 13'h1010;
  // protection counters
  localparam int GUARD_COUNT_WIDTH = 3;
  localparam logic [2:0] SHORT_TRIP_COUNT = 3'h4;
  localparam logic [2:0] OVER_TRIP_COUNT = 3'h4;
  localparam int DAC_WIDTH = 8;
  localparam logic [7:0] DAC_MAX = 8'hff;
  localparam int DOT_WIDTH = 21;
  // output stagger
  localparam int CLK_PERIOD_NS = 5;
  localparam int STAGGER_NS = 40;
  localparam int STAGGER_CYC =
    (STAGGER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SINK_COUNT = 3;
  // supervisor states
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_SHORT = 4'h2,
    ST_THERM = 4'h4,
    ST_WAKE = 4'h8
  } ldp_state_type;
endpackage : ldp_pkg

// >>> core/ldp_protect.sv
// protection, status snapshot and grayscale timing of the led sink driver
// How it works
// - snapshot bits 0-4 open, short, over, pretherm, therm; 35-5 reserved
// - short trip stops converter, over trip only the leds; restart write after a short trip brings soft start
// - converter on: one or two open leds or grounded sink set open flag
// - all three leds open raise the overvoltage flag instead of open flag
// - converter off: sample low comparators at 33rd clock, hold result
// - short counter counts switch node events while feedback is low
// - count of four with feedback low stops converter and leds, loads dac
// - serial interface keeps working while converter is stopped by a guard
// - converter disabled: overvoltage guard off and its flag reads zero
// - at 33rd clock reset overvoltage counter below max code, count at max
// - over count of four stops leds, loads dac, converter keeps running
// - leds stay off after over trip until restart write, which clears flag
// - pre-thermal forces sinks off and sets log; resumes when it clears
// - thermal stop kills converter, sinks, interface; sets log, loads dac
// - thermal clear restarts interface first and converter afterwards, unless the short flag is still set
// - dac pre-boost runs from the 16th clock and ends at the 33rd
// - outputs turn on from the 17th clock; a period is 4112 clocks
// - lockout initialises control and timing and clears the shift register
// - lockout copies stored dot correction values into the dot latch
// - the three sink outputs switch about 40 ns apart
// - status write loads snapshot into low 36 bits, address stays on top
// - thermal logs stay set until a status write loads the snapshot
module ldp_protect
  import ldp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic converter_disable_input_i,
  input wire logic shift_tick_i,
  input wire logic shift_data_i,
  input wire logic write_strobe_i,
  input wire logic grayscale_tick_i,
  input wire logic grayscale_restart_i,
  input wire logic [35:0] grayscale_value_i,
  input wire logic [2:0] led_open_i,
  input wire logic [2:0] sink_grounded_i,
  input wire logic [2:0] sink_low_i,
  input wire logic anode_feedback_low_i,
  input wire logic switch_node_event_i,
  input wire logic [7:0] dac_code_i,
  input wire logic [7:0] stored_feedback_i,
  input wire logic [20:0] stored_dot_correction_i,
  input wire logic pre_thermal_stop_i,
  input wire logic thermal_stop_i,
  output logic shift_data_o,
  output logic converter_run_o,
  output logic soft_start_o,
  output logic dac_load_o,
  output logic [7:0] dac_target_o,
  output logic dac_boost_o,
  output logic led_enable_o,
  output logic interface_enable_o,
  output logic [20:0] dot_correction_o,
  output logic [2:0] sink_output_o,
  output logic [35:0] status_snapshot_o
);
  // sink window: on from the first led clock for value clocks
  function automatic logic sink_window(input logic [12:0] count,
                                       input logic [11:0] value);
    logic [12:0] lit;
    lit = count - GS_LED_FIRST;
    sink_window = (count >= GS_LED_FIRST) && (lit < {1'b0, value});
  endfunction : sink_window

  // number of open leds
  function automatic logic [1:0] open_count(input logic [2:0] open);
    open_count = {1'b0, open[0]} + {1'b0, open[1]} + {1'b0, open[2]};
  endfunction : open_count

  ldp_state_type state;
  ldp_state_type next_state;
  logic [39:0] shift_reg;
  logic [12:0] grayscale_count;
  logic [2:0] short_count;
  logic [2:0] over_count;
  logic open_flag;
  logic short_flag;
  logic over_flag;
  logic pre_thermal_log;
  logic thermal_log;
  logic dot_loaded;
  logic [2:0] sink_request;

  ldp_sink_if sink ();

  ldp_stagger u_stagger (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .sink(sink)
  );

  // command decode; the interface is dead only in thermal stop
  wire interface_live = (state != ST_THERM);
  wire write_cmd = write_strobe_i && interface_live;
  wire [3:0] write_addr = shift_reg[39:36];
  wire restart_cmd = write_cmd && (write_addr == ADDR_RESTART);
  wire status_cmd = write_cmd && (write_addr == ADDR_STATUS);
  wire converter_on = !converter_disable_input_i;

  // grayscale events
  wire sample_now = grayscale_tick_i && (grayscale_count == GS_SAMPLE - 13'h1);
  wire boost_window = (grayscale_count >= GS_BOOST_FIRST)
                      && (grayscale_count < GS_SAMPLE);

  // short circuit guard trips only while the converter is enabled
  wire short_trip = (state == ST_RUN) && converter_on && anode_feedback_low_i
                    && (short_count == SHORT_TRIP_COUNT);

  // overvoltage guard
  wire over_trip = converter_on && !over_flag
                   && (over_count == OVER_TRIP_COUNT);
  wire [1:0] opens = open_count(led_open_i);
  // with every led open no sink pin rises, so only the over flag can tell
  wire all_open = converter_on && led_enable_o && (opens == 2'h3);
  wire some_open = ((opens == 2'h1) || (opens == 2'h2))
                   || (|sink_grounded_i);

  // flag and log next values: a new event wins over a clear
  wire next_short_flag = short_trip || (short_flag && !restart_cmd);
  wire next_over_flag = over_trip || all_open
                        || (over_flag && !restart_cmd);
  wire next_pre_thermal = pre_thermal_stop_i
                          || (pre_thermal_log && !status_cmd);
  wire next_thermal = thermal_stop_i || (thermal_log && !status_cmd);
  wire next_led_enable = (next_state == ST_RUN) && !next_over_flag
                         && !pre_thermal_stop_i;

  // snapshot as the host would read it now; reserved bits read zero
  wire [35:0] snapshot = {31'h0, thermal_log, pre_thermal_log,
                          over_flag && converter_on,
                          short_flag, open_flag};

  // supervisor transitions; thermal stop overrides everything
  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        if (short_trip) begin
          next_state = ST_SHORT;
        end
      end
      ST_SHORT: begin
        if (restart_cmd) begin
          next_state = ST_RUN;
        end
      end
      ST_THERM: begin
        if (!thermal_stop_i) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        next_state = short_flag ? ST_SHORT : ST_RUN;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
    if (thermal_stop_i) begin
      next_state = ST_THERM;
    end
  end

  // per channel lit window, gated by the led enable
  assign sink_request[0] = led_enable_o
                           && sink_window(grayscale_count,
                                          grayscale_value_i[11:0]);
  assign sink_request[1] = led_enable_o
                           && sink_window(grayscale_count,
                                          grayscale_value_i[23:12]);
  assign sink_request[2] = led_enable_o
                           && sink_window(grayscale_count,
                                          grayscale_value_i[35:24]);
  assign sink.request = sink_request;
  assign sink_output_o = sink.drive;

  // supervisor state, lockout returns it to normal running
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // grayscale counter holds at the period end until the next restart
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      grayscale_count <= 13'h0;
    end else if (grayscale_restart_i) begin
      grayscale_count <= 13'h0;
    end else if (grayscale_tick_i && (grayscale_count != GS_PERIOD)) begin
      grayscale_count <= grayscale_count + 13'h1;
    end
  end

  // short counter counts switch node events while feedback stays low
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      short_count <= 3'h0;
    end else if (restart_cmd || !anode_feedback_low_i) begin
      short_count <= 3'h0;
    end else if (switch_node_event_i
                 && (short_count != SHORT_TRIP_COUNT)) begin
      short_count <= short_count + 3'h1;
    end
  end

  // overvoltage period counter, checked once per period at the sample clock
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      over_count <= 3'h0;
    end else if (restart_cmd || !converter_on) begin
      over_count <= 3'h0;
    end else if (sample_now && !over_flag) begin
      if (dac_code_i != DAC_MAX) begin
        over_count <= 3'h0;
      end else if (over_count != OVER_TRIP_COUNT) begin
        over_count <= over_count + 3'h1;
      end
    end
  end

  // open detection: live with the converter, sampled and held without it
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      open_flag <= 1'b0;
    end else if (converter_on) begin
      open_flag <= some_open;
    end else if (sample_now) begin
      open_flag <= |(sink_low_i & sink_request);
    end
  end

  // fault flags and logs
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      short_flag <= 1'b0;
      over_flag <= 1'b0;
      pre_thermal_log <= 1'b0;
      thermal_log <= 1'b0;
    end else begin
      short_flag <= next_short_flag;
      over_flag <= next_over_flag;
      pre_thermal_log <= next_pre_thermal;
      thermal_log <= next_thermal;
    end
  end

  // 40-bit shift register; a status write keeps the address nibble on top
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      shift_reg <= 40'h0;
    end else if (status_cmd) begin
      shift_reg <= {ADDR_STATUS, snapshot};
    end else if (shift_tick_i && interface_live) begin
      shift_reg <= {shift_reg[38:0], shift_data_i};
    end
  end

  // dot correction copied once, on the first edge after lockout ends
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      dot_loaded <= 1'b0;
      dot_correction_o <= 21'h0;
    end else if (!dot_loaded) begin
      dot_loaded <= 1'b1;
      dot_correction_o <= stored_dot_correction_i;
    end
  end

  // converter and driver controls, all registered
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      converter_run_o <= 1'b0;
      soft_start_o <= 1'b0;
      dac_load_o <= 1'b0;
      dac_target_o <= 8'h0;
      dac_boost_o <= 1'b0;
      led_enable_o <= 1'b0;
      interface_enable_o <= 1'b0;
      shift_data_o <= 1'b0;
      status_snapshot_o <= 36'h0;
    end else begin
      converter_run_o <= converter_on && (next_state == ST_RUN);
      soft_start_o <= converter_on && (next_state == ST_RUN)
                      && (state != ST_RUN);
      dac_load_o <= short_trip || over_trip
                    || (thermal_stop_i && (state != ST_THERM));
      dac_target_o <= stored_feedback_i;
      dac_boost_o <= boost_window && (state == ST_RUN);
      led_enable_o <= next_led_enable;
      interface_enable_o <= (next_state != ST_THERM);
      shift_data_o <= shift_reg[39];
      status_snapshot_o <= snapshot;
    end
  end
endmodule : ldp_protect

// >>> core/ldp_sink_if.sv
// sink output request and staggered drive between controller and stagger
interface ldp_sink_if;
  logic [2:0] request;
  logic [2:0] drive;
  modport ctrl (output request, input drive);
  modport stag (input request, output drive);
endinterface : ldp_sink_if

// >>> core/ldp_stagger.sv
// delay line that spreads sink output switching over time
module ldp_stagger
  import ldp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  ldp_sink_if.stag sink
);
  localparam int DEPTH = 2 * STAGGER_CYC + 1;

  logic [2:0] line [DEPTH];

  // one shared line; channel n taps n stagger steps deep, so both edges
  // of every channel are spread alike at the cost of a few flops
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < DEPTH; i++) begin
        line[i] <= 3'h0;
      end
    end else begin
      line[0] <= sink.request;
      for (int i = 1; i < DEPTH; i++) begin
        line[i] <= line[i-1];
      end
    end
  end

  // taps come straight from flops
  assign sink.drive[0] = line[0][0];
  assign sink.drive[1] = line[STAGGER_CYC][1];
  assign sink.drive[2] = line[2*STAGGER_CYC][2];
endmodule : ldp_stagger

// >>> tb/ldp_host.sv
// host controller model on the serial command link
module ldp_host
  import ldp_pkg::*;
(
  input wire logic clk_i,
  input wire logic serial_i,
  output logic tick_o,
  output logic data_o,
  output logic strobe_o,
  output logic [39:0] word_o,
  output logic word_valid_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {tick_o, data_o, strobe_o, word_valid_o} = 4'h0;
    word_o = 40'h0;
  end
  // shift a command in msb first, then latch it
  task automatic send(input logic [39:0] w);
    for (int i = 39; i >= 0; i--) begin
      @(negedge clk_i);
      data_o = w[i];
      tick_o = 1'b1;
    end
    @(negedge clk_i);
    tick_o = 1'b0;
    data_o = ~data_o; // idle line does not keep the last bit
    strobe_o = 1'b1;
    @(negedge clk_i);
    strobe_o = 1'b0;
  endtask : send
  // ask for a snapshot, then clock all 40 bits back out
  task automatic read_status();
    send({ADDR_STATUS, 36'h0});
    @(negedge clk_i);
    for (int i = 39; i >= 0; i--) begin
      word_o[i] = serial_i;
      tick_o = 1'b1;
      @(negedge clk_i);
      tick_o = 1'b0;
      @(negedge clk_i);
    end
    word_valid_o = 1'b1;
    @(negedge clk_i);
    word_valid_o = 1'b0;
  endtask : read_status
endmodule : ldp_host

// >>> tb/ldp_protect_props.sv
// port-level assertions for the protection block
module ldp_protect_props
  import ldp_pkg::*;
(
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic converter_disable_input_i,
  input wire logic pre_thermal_stop_i,
  input wire logic thermal_stop_i,
  input wire logic [20:0] stored_dot_correction_i,
  input wire logic converter_run_o,
  input wire logic soft_start_o,
  input wire logic dac_load_o,
  input wire logic led_enable_o,
  input wire logic interface_enable_o,
  input wire logic [20:0] dot_correction_o,
  input wire logic [2:0] sink_output_o,
  input wire logic [35:0] status_snapshot_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] up_cnt;
  logic [4:0] off_cnt;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // saturating counts: time since reset, time with sinks disallowed
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      up_cnt <= 5'h00;
      off_cnt <= 5'h00;
    end else begin
      up_cnt <= up_cnt + {4'h0, up_cnt != 5'h1f};
      off_cnt <= led_enable_o ? 5'h00 : off_cnt + {4'h0, off_cnt != 5'h1f};
    end
  end
  AST_RESERVED: assert property (status_snapshot_o[35:5] == 31'h0)
    else $error("reserved snapshot bits not zero");
  AST_OVER_OFF: assert property (converter_disable_input_i &&
    $past(converter_disable_input_i) |-> !status_snapshot_o[2])
    else $error("over flag set with converter disabled");
  AST_SHORT_STOP: assert property ($rose(status_snapshot_o[1]) |->
    !converter_run_o && !led_enable_o && $past(dac_load_o))
    else $error("short trip did not stop converter and leds");
  AST_OVER_HOLD: assert property (status_snapshot_o[2] |->
    !$past(led_enable_o))
    else $error("leds enabled while over flag set");
  AST_OVER_RUN: assert property ($rose(status_snapshot_o[2]) |->
    converter_run_o == $past(converter_run_o, 2))
    else $error("over trip changed the converter state");
  AST_THERM: assert property (thermal_stop_i |=> (!converter_run_o &&
    !interface_enable_o && !led_enable_o) ##1 status_snapshot_o[4])
    else $error("thermal stop not applied");
  AST_WAKE: assert property ($rose(interface_enable_o) &&
    up_cnt > 5'h02 && !status_snapshot_o[1] |->
    !converter_run_o ##1 (converter_run_o && soft_start_o))
    else $error("thermal wake order wrong");
  AST_PRETHERM: assert property (pre_thermal_stop_i |=>
    !led_enable_o ##1 status_snapshot_o[3])
    else $error("pre-thermal did not stop leds");
  AST_SINK_OFF: assert property (off_cnt > 5'h14 |->
    sink_output_o == 3'h0)
    else $error("sinks on while leds disabled");
  AST_STAGGER: assert property (up_cnt == 5'h1f |->
    sink_output_o[1] == $past(sink_output_o[0], 8) &&
    sink_output_o[2] == $past(sink_output_o[1], 8))
    else $error("sink outputs not spread apart");
  AST_SOFT: assert property (soft_start_o |->
    converter_run_o && !$past(converter_run_o))
    else $error("soft start without converter restart");
  AST_DOT: assert property (up_cnt == 5'h01 |->
    dot_correction_o == $past(stored_dot_correction_i))
    else $error("dot correction not copied at lockout");
endmodule : ldp_protect_props
bind ldp_protect ldp_protect_props props_u (.*);

// >>> tb/ldp_protect_test.sv
// self-checking bench of the protection block
module ldp_protect_test
  import ldp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0, reset_i = 1'b1, converter_disable_input_i = 1'b0;
  logic shift_tick_i, shift_data_i, write_strobe_i;
  logic grayscale_tick_i = 1'b0, grayscale_restart_i = 1'b0;
  logic [35:0] grayscale_value_i = 36'h0;
  logic [2:0] led_open_i = 3'h0, sink_grounded_i = 3'h0, sink_low_i = 3'h0;
  logic anode_feedback_low_i = 1'b0, switch_node_event_i = 1'b0;
  logic [7:0] dac_code_i = 8'h00, stored_feedback_i = 8'h00;
  logic [20:0] stored_dot_correction_i = 21'h0;
  logic pre_thermal_stop_i = 1'b0, thermal_stop_i = 1'b0;
  logic shift_data_o, converter_run_o, soft_start_o, dac_load_o;
  logic dac_boost_o, led_enable_o, interface_enable_o, word_valid;
  logic [7:0] dac_target_o;
  logic [20:0] dot_correction_o;
  logic [2:0] sink_output_o;
  logic [35:0] status_snapshot_o;
  logic [39:0] word;
  logic [39:0] expq[$];
  logic [31:0] seed = 32'h000144d8;
  int n_fail = 0;
  int comparisons = 0;
  ldp_protect dut_u (.*);
  ldp_host host_u (.clk_i(clk_i), .serial_i(shift_data_o),
    .tick_o(shift_tick_i), .data_o(shift_data_i),
    .strobe_o(write_strobe_i), .word_o(word), .word_valid_o(word_valid));
  always #2.5 clk_i = ~clk_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input string what, input logic [39:0] got,
                       input logic [39:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic results();
    if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : results
  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask : cyc
  // one-cycle pulses: 0 grayscale tick, 1 switch event, 2 counter restart
  task automatic pulse(input int which, input int n);
    repeat (n) begin
      @(negedge clk_i);
      grayscale_tick_i = (which == 0);
      switch_node_event_i = (which == 1);
      grayscale_restart_i = (which == 2);
      @(negedge clk_i);
      {grayscale_tick_i, switch_node_event_i, grayscale_restart_i} = 3'h0;
    end
  endtask : pulse
  task automatic rd(input logic [4:0] flags);
    expq.push_back({ADDR_STATUS, 31'h0, flags});
    host_u.read_status();
  endtask : rd
  task automatic restart();
    host_u.send({ADDR_RESTART, 36'(rnd())});
    cyc(2);
  endtask : restart
  // each shifted-out word is matched against the oldest note
  always @(posedge clk_i) begin
    if (word_valid === 1'b1) begin
      if (expq.size() == 0) check("unexpected word", word, 40'h0);
      else check("status word", word, expq.pop_front());
    end
  end
  // a hung handshake ends the run as a failure
  initial begin
    #100000;
    n_fail++;
    results();
  end
  initial begin
    logic [31:0] r;
    {stored_feedback_i, stored_dot_correction_i} = 29'(rnd());
    r = rnd();
    grayscale_value_i = {3{12'h021 + {2'h0, r[9:0]}}};
    cyc(4);
    reset_i = 1'b0;
    cyc(2);
    check("dot", 40'(dot_correction_o), 40'(stored_dot_correction_i));
    check("shift out", 40'(shift_data_o), 40'h0);
    rd(5'h00);
    led_open_i = 3'h1;
    cyc(3);
    rd(5'h01);
    led_open_i = 3'h0;
    sink_grounded_i = 3'h4;
    cyc(3);
    rd(5'h01);
    sink_grounded_i = 3'h0;
    led_open_i = 3'h7;
    cyc(3);
    rd(5'h04);
    led_open_i = 3'h0;
    restart();
    check("led after restart", 40'(led_enable_o), 40'h1);
    rd(5'h00);
    // period counter: a below-max period clears the count
    dac_code_i = 8'hff;
    pulse(2, 1);
    pulse(0, 33);
    dac_code_i = 8'h80;
    pulse(2, 1);
    pulse(0, 33);
    dac_code_i = 8'hff;
    repeat (3) begin
      pulse(2, 1);
      pulse(0, 33);
    end
    check("led before trip", 40'(led_enable_o), 40'h1);
    pulse(2, 1);
    pulse(0, 33);
    cyc(2);
    check("led over", 40'(led_enable_o), 40'h0);
    check("run over", 40'(converter_run_o), 40'h1);
    rd(5'h04);
    dac_code_i = 8'h00;
    restart();
    // short guard trips on the fourth switching event
    anode_feedback_low_i = 1'b1;
    pulse(1, 3);
    check("run at three", 40'(converter_run_o), 40'h1);
    pulse(1, 1);
    cyc(2);
    check("run short", 40'(converter_run_o), 40'h0);
    check("target", 40'(dac_target_o), 40'(stored_feedback_i));
    rd(5'h02);
    anode_feedback_low_i = 1'b0;
    restart();
    check("run restart", 40'(converter_run_o), 40'h1);
    rd(5'h00);
    pre_thermal_stop_i = 1'b1;
    cyc(3);
    check("led pretherm", 40'(led_enable_o), 40'h0);
    pre_thermal_stop_i = 1'b0;
    cyc(3);
    check("led resumed", 40'(led_enable_o), 40'h1);
    rd(5'h08);
    rd(5'h00);
    thermal_stop_i = 1'b1;
    cyc(3);
    check("if therm", 40'(interface_enable_o), 40'h0);
    thermal_stop_i = 1'b0;
    cyc(1);
    check("wake", 40'({interface_enable_o, converter_run_o}), 40'h2);
    cyc(1);
    check("wake run", 40'(converter_run_o), 40'h1);
    rd(5'h10);
    // converter disabled: sampled open detect and output timing
    converter_disable_input_i = 1'b1;
    sink_low_i = 3'h2;
    pulse(2, 1);
    pulse(0, 16);
    cyc(24);
    check("sinks early", 40'(sink_output_o), 40'h0);
    check("boost", 40'(dac_boost_o), 40'h1);
    pulse(0, 1);
    cyc(24);
    check("sinks on", 40'(sink_output_o), 40'h7);
    pulse(0, 16);
    cyc(2);
    check("boost end", 40'(dac_boost_o), 40'h0);
    rd(5'h01);
    sink_low_i = 3'h0;
    pulse(2, 1);
    pulse(0, 33);
    rd(5'h00);
    reset_i = 1'b1;
    cyc(2);
    reset_i = 1'b0;
    cyc(2);
    rd(5'h00);
    results();
  end
endmodule : ldp_protect_test
